// *** rtl/wgct_pkg.sv ***
// Package: register map, field layout, reset values and timing for the gated counter timer
`default_nettype none
package wgct_pkg;
    // Register byte addresses (printed offsets are not all multiples of four: index * 4)
    localparam logic [7:0] WGCT_IDX_CTRL1   = 8'h14;
    localparam logic [7:0] WGCT_IDX_CTRL2   = 8'h15;
    localparam logic [7:0] WGCT_IDX_STATUS  = 8'h16;
    localparam logic [7:0] WGCT_IDX_COMPARE = 8'h11;
    localparam logic [7:0] WGCT_IDX_GATEPER = 8'h13;
    localparam logic [7:0] WGCT_IDX_SYSMODE = 8'h20;
    localparam logic [9:0] WGCT_ADDR_CTRL1   = {WGCT_IDX_CTRL1, 2'b00};
    localparam logic [9:0] WGCT_ADDR_CTRL2   = {WGCT_IDX_CTRL2, 2'b00};
    localparam logic [9:0] WGCT_ADDR_STATUS  = {WGCT_IDX_STATUS, 2'b00};
    localparam logic [9:0] WGCT_ADDR_COMPARE = {WGCT_IDX_COMPARE, 2'b00};
    localparam logic [9:0] WGCT_ADDR_GATEPER = {WGCT_IDX_GATEPER, 2'b00};
    localparam logic [9:0] WGCT_ADDR_SYSMODE = {WGCT_IDX_SYSMODE, 2'b00};
    // Field positions
    localparam int WGCT_CR1_CLR    = 7;
    localparam int WGCT_CR1_RUN_HI = 5;
    localparam int WGCT_CR1_RUN_LO = 4;
    localparam int WGCT_CR1_CK_HI  = 3;
    localparam int WGCT_CR1_CK_LO  = 1;
    localparam int WGCT_CR2_SGP_HI = 6;
    localparam int WGCT_CR2_SGP_LO = 5;
    localparam int WGCT_CR2_EDG    = 4;
    localparam int WGCT_CR2_WCK_HI = 3;
    localparam int WGCT_CR2_WCK_LO = 2;
    localparam int WGCT_SR_ACTIVE  = 7;
    localparam int WGCT_SR_OVF     = 6;
    // Reset values
    localparam logic [7:0]  WGCT_CR1_RESET  = 8'h88;
    localparam logic [7:0]  WGCT_CR2_RESET  = 8'h02;
    localparam logic [17:0] WGCT_CMP_RESET  = 18'h0_0001;
    localparam logic [7:0]  WGCT_GPER_RESET = 8'h00;
    localparam logic [17:0] WGCT_CNT_MAX    = 18'h3_FFFF;
    // Source clock codes
    localparam logic [2:0] WGCT_CK_FC   = 3'h0;
    localparam logic [2:0] WGCT_CK_FS   = 3'h1;
    localparam logic [2:0] WGCT_CK_EXT  = 3'h7;
    localparam logic [1:0] WGCT_RUN_START = 2'h2;
    // Divider exponents for high and low frequency chains
    localparam int WGCT_PRE_W = 24;
    localparam int WGCT_FS_W  = 16;
    localparam int WGCT_GATE_HI_BASE = 12;
    localparam int WGCT_GATE_LO_BASE = 4;
    localparam int WGCT_SLOW_MASK_BITS = 11;
    // Clock rate: 10 MHz core clock; fs is a divided strobe of this clock
    localparam int WGCT_CLK_HZ = 10_000_000;
    localparam int WGCT_FS_HZ  = 32_768;
    localparam int WGCT_FS_DIV = WGCT_CLK_HZ / WGCT_FS_HZ;
    // System operating modes driven by the system mode register
    typedef enum logic [1:0] {WGCT_SYS_NORMAL, WGCT_SYS_IDLE, WGCT_SYS_SLOW, WGCT_SYS_SLEEP}
        wgct_sys_t;
endpackage
`default_nettype wire

// *** rtl/wgct_gate_gen.sv ***
// Internal window gate generator: high period Ta, low period Tb in gate ticks
`default_nettype none
module wgct_gate_gen
    import wgct_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       enable,
    input  wire logic       tick,
    input  wire logic [3:0] high_set,
    input  wire logic [3:0] low_set,
    output logic            gate
);
    logic       gate_q, gate_d;
    logic [4:0] left_q, left_d;

    // Gate runs 16 - setting ticks per phase; low period reloads at phase start
    always_comb
    begin
        gate_d = gate_q;
        left_d = left_q;
        if (!enable)
        begin
            gate_d = 1'b0;
            left_d = 5'd16 - {1'b0, low_set};
        end
        else if (tick)
        begin
            if (left_q <= 5'd1)
            begin
                gate_d = ~gate_q;
                left_d = gate_q ? 5'd16 - {1'b0, low_set} : 5'd16 - {1'b0, high_set};
            end
            else
            begin
                left_d = left_q - 5'd1;
            end
        end
    end

    // State registers
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            gate_q <= 1'b0;
            left_q <= 5'd16;
        end
        else
        begin
            gate_q <= gate_d;
            left_q <= left_d;
        end
    end

    assign gate = gate_q;
endmodule
`default_nettype wire

// *** rtl/wgct_top.sv ***
// Window gated 18-bit counter timer with AHB-Lite register slave
// Behaviour
// - Gate code 01 internal generator, 10 reserved
// - Gate code 00 uses external pin directly
// - Edge select bit picks gate interrupt edges
// - Choices: falling only, or both edges
// - Gate tick 2^12/13/14 fc normally
// - Status bit7 shows counting in gate high
// - Status bit6 overflow; bits5..0 zero, read-only
// - Wrap to zero sets overflow until clear
// - Four modes; timer serves warm-up delay
// - Timer counts internal clock, compares always
// - Match raises interrupt, clears, keeps counting
// - Source clock table for fc and fs
// - Slow mode fc: compare upper 7 bits only
// - Event mode counts external falling edges
// - Event match interrupts and clears counter
//
// Decided for this implementation: register access over AHB-Lite.
`default_nettype none
module wgct_top
    import wgct_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        external_count_input,
    output logic             match_interrupt,
    output logic             gate_interrupt
);
    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave: address phase capture, one-cycle data phase, always ready
    logic       wr_pend_q, wr_pend_d;
    logic [9:0] wr_addr_q, wr_addr_d;
    logic       addr_ok;
    logic [31:0] rd_d;
    logic [31:0] hrdata_q;

    assign addr_ok   = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Registers seen by software
    logic [7:0]  cr1_q, cr1_d;
    logic [7:0]  cr2_q, cr2_d;
    logic [17:0] cmp_q, cmp_d;
    logic [7:0]  gper_q, gper_d;
    logic [2:0]  sys_q, sys_d;
    logic [17:0] cnt_q, cnt_d;
    logic        ovf_q, ovf_d;
    logic        match_q, match_d;
    logic        gint_q, gint_d;

    logic        wr_cr1, wr_cr2, wr_cmp, wr_gper, wr_sys;
    assign wr_cr1  = wr_pend_q && wr_addr_q == WGCT_ADDR_CTRL1;
    assign wr_cr2  = wr_pend_q && wr_addr_q == WGCT_ADDR_CTRL2;
    assign wr_cmp  = wr_pend_q && wr_addr_q == WGCT_ADDR_COMPARE;
    assign wr_gper = wr_pend_q && wr_addr_q == WGCT_ADDR_GATEPER;
    assign wr_sys  = wr_pend_q && wr_addr_q == WGCT_ADDR_SYSMODE;

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded configuration
    logic [1:0] run_ctl;
    logic [2:0] ck_sel;
    logic [1:0] gate_src;
    logic       edge_both;
    logic [1:0] gate_ck;
    logic       running;
    logic       low_div;
    logic       slow_dom;
    assign run_ctl   = cr1_q[WGCT_CR1_RUN_HI:WGCT_CR1_RUN_LO];
    assign ck_sel    = cr1_q[WGCT_CR1_CK_HI:WGCT_CR1_CK_LO];
    assign gate_src  = cr2_q[WGCT_CR2_SGP_HI:WGCT_CR2_SGP_LO];
    assign edge_both = cr2_q[WGCT_CR2_EDG];
    assign gate_ck   = cr2_q[WGCT_CR2_WCK_HI:WGCT_CR2_WCK_LO];
    assign running   = run_ctl == WGCT_RUN_START;
    // Bit 2 of the system register selects the low-frequency divider in normal mode
    assign slow_dom  = sys_q[1:0] == WGCT_SYS_SLOW || sys_q[1:0] == WGCT_SYS_SLEEP;
    assign low_div   = sys_q[2] || slow_dom;

    ////////////////////////////////////////////////////////////////////////////////
    // Prescalers: high chain counts core clocks, low chain counts fs strobes
    logic [WGCT_PRE_W-1:0] pre_q, pre_d;
    logic [WGCT_FS_W-1:0]  fsp_q, fsp_d;
    logic [8:0]            fsdiv_q, fsdiv_d;
    logic                  fs_tick;
    logic [WGCT_PRE_W-1:0] fc_tap;
    logic [WGCT_FS_W-1:0]  fs_tap;

    assign fs_tick = fsdiv_q == 9'(WGCT_FS_DIV - 1);

    // Tap pulse per bit: bit k wraps every 2^(k+1) clocks of its chain
    genvar gi;
    generate
        for (gi = 0; gi < WGCT_PRE_W; gi++)
        begin : g_fc_tap
            assign fc_tap[gi] = &pre_q[gi:0];
        end
        for (gi = 0; gi < WGCT_FS_W; gi++)
        begin : g_fs_tap
            assign fs_tap[gi] = fs_tick && (&fsp_q[gi:0]);
        end
    endgenerate

    always_comb
    begin
        pre_d   = pre_q + 1'b1;
        fsdiv_d = fs_tick ? 9'd0 : fsdiv_q + 9'd1;
        fsp_d   = fs_tick ? fsp_q + 1'b1 : fsp_q;
    end

    // Source clock strobe selection
    logic src_tick;
    always_comb
    begin
        case (ck_sel)
            3'h0:    src_tick = 1'b1;
            3'h1:    src_tick = fs_tick;
            3'h2:    src_tick = low_div ? fs_tap[14] : fc_tap[22];
            3'h3:    src_tick = low_div ? fs_tap[4]  : fc_tap[12];
            3'h4:    src_tick = low_div ? fs_tap[2]  : fc_tap[10];
            3'h5:    src_tick = slow_dom ? 1'b0 : fc_tap[6];
            3'h6:    src_tick = slow_dom ? 1'b0 : fc_tap[2];
            default: src_tick = 1'b0;
        endcase
    end

    // Window gate tick
    logic gate_tick;
    always_comb
    begin
        case (gate_ck)
            2'h0:    gate_tick = low_div ? fs_tap[3] : fc_tap[11];
            2'h1:    gate_tick = low_div ? fs_tap[4] : fc_tap[12];
            2'h2:    gate_tick = low_div ? fs_tap[5] : fc_tap[13];
            default: gate_tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // External input: two-flop synchroniser, then falling edge detect
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic ext_fall;
    assign ext_fall = ext_s3_q && !ext_s2_q;

    // Window gate source
    logic int_gate, gate_now, gate_prev_q;
    wgct_gate_gen u_gate (
        .core_clk (core_clk),
        .reset    (reset),
        .enable   (running && gate_src == 2'b01),
        .tick     (gate_tick),
        .high_set (gper_q[7:4]),
        .low_set  (gper_q[3:0]),
        .gate     (int_gate)
    );
    always_comb
    begin
        case (gate_src)
            2'b00:   gate_now = ext_s2_q;
            2'b01:   gate_now = int_gate;
            default: gate_now = 1'b0;                         // Reserved codes hold gate low
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counter, compare match and overflow
    logic cnt_tick, hit, cnt_clear;
    logic [17:0] cmp_mask;
    assign cnt_tick  = running && (ck_sel == WGCT_CK_EXT ? ext_fall : src_tick);
    // Slow mode with fc: low bits take no part in the compare
    assign cmp_mask  = (slow_dom && ck_sel == WGCT_CK_FC) ?
                       {7'h7f, {WGCT_SLOW_MASK_BITS{1'b0}}} : WGCT_CNT_MAX;
    assign hit       = running && ((cnt_q & cmp_mask) == (cmp_q & cmp_mask));
    assign cnt_clear = wr_cr1 && !hwdata[WGCT_CR1_CLR];

    always_comb
    begin
        cnt_d   = cnt_q;
        ovf_d   = ovf_q;
        match_d = 1'b0;
        gint_d  = 1'b0;
        if (hit && cnt_tick)
        begin
            match_d = 1'b1;
            cnt_d   = 18'h0_0000;
        end
        else if (cnt_tick)
        begin
            cnt_d = cnt_q + 18'h0_0001;
            if (cnt_q == WGCT_CNT_MAX)
            begin
                ovf_d = 1'b1;
            end
        end
        // Clear command loses to a same-cycle wrap so no overflow is missed
        if (cnt_clear)
        begin
            cnt_d = 18'h0_0000;
            if (!(cnt_tick && cnt_q == WGCT_CNT_MAX))
            begin
                ovf_d = 1'b0;
            end
        end
        // Gate edge interrupt
        if (running && gate_prev_q && !gate_now)
        begin
            gint_d = 1'b1;
        end
        else if (running && edge_both && !gate_prev_q && gate_now)
        begin
            gint_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes; stray fixed bits forced to their required values
    always_comb
    begin
        cr1_d  = cr1_q;
        cr2_d  = cr2_q;
        cmp_d  = cmp_q;
        gper_d = gper_q;
        sys_d  = sys_q;
        // Writes land regardless of run state; stopping first is software's duty
        if (wr_cr1)
        begin
            cr1_d = {1'b1, hwdata[6:0]};                      // Clear bit self-restores
        end
        if (wr_cr2)
        begin
            cr2_d = {1'b0, hwdata[6:2], 2'b10};
        end
        if (wr_cmp)
        begin
            cmp_d = hwdata[17:0];
        end
        if (wr_gper)
        begin
            gper_d = hwdata[7:0];
        end
        if (wr_sys)
        begin
            sys_d = hwdata[2:0];
        end
    end

    // Read mux; status low bits read zero
    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (haddr[9:0])
            WGCT_ADDR_CTRL1:   rd_d = {24'h00_0000, cr1_q};
            WGCT_ADDR_CTRL2:   rd_d = {24'h00_0000, cr2_q};
            WGCT_ADDR_STATUS:  rd_d = {24'h00_0000, running && gate_now, ovf_q, 6'b00_0000};
            WGCT_ADDR_COMPARE: rd_d = {14'h0000, cnt_q};
            WGCT_ADDR_GATEPER: rd_d = {24'h00_0000, gper_q};
            WGCT_ADDR_SYSMODE: rd_d = {29'h0000_0000, sys_q};
            default:           rd_d = 32'h0000_0000;
        endcase
        wr_pend_d = addr_ok && hwrite;
        wr_addr_d = haddr[9:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 10'h000;
            hrdata_q    <= 32'h0000_0000;
            cr1_q       <= WGCT_CR1_RESET;
            cr2_q       <= WGCT_CR2_RESET;
            cmp_q       <= WGCT_CMP_RESET;
            gper_q      <= WGCT_GPER_RESET;
            sys_q       <= 3'h0;
            cnt_q       <= 18'h0_0000;
            ovf_q       <= 1'b0;
            match_q     <= 1'b0;
            gint_q      <= 1'b0;
            pre_q       <= '0;
            fsp_q       <= '0;
            fsdiv_q     <= 9'h000;
            ext_s1_q    <= 1'b0;
            ext_s2_q    <= 1'b0;
            ext_s3_q    <= 1'b0;
            gate_prev_q <= 1'b0;
        end
        else
        begin
            wr_pend_q   <= wr_pend_d;
            wr_addr_q   <= wr_addr_d;
            hrdata_q    <= (addr_ok && !hwrite) ? rd_d : hrdata_q;
            cr1_q       <= cr1_d;
            cr2_q       <= cr2_d;
            cmp_q       <= cmp_d;
            gper_q      <= gper_d;
            sys_q       <= sys_d;
            cnt_q       <= cnt_d;
            ovf_q       <= ovf_d;
            match_q     <= match_d;
            gint_q      <= gint_d;
            pre_q       <= pre_d;
            fsp_q       <= fsp_d;
            fsdiv_q     <= fsdiv_d;
            ext_s1_q    <= external_count_input;
            ext_s2_q    <= ext_s1_q;
            ext_s3_q    <= ext_s2_q;
            gate_prev_q <= gate_now;
        end
    end

    assign hrdata          = hrdata_q;
    assign match_interrupt = match_q;
    assign gate_interrupt  = gint_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_fall_seen;
        ext_s3_q && !ext_s2_q;
    endsequence

    a_match_clears: assert property (@(posedge core_clk) disable iff (reset)
        hit && cnt_tick && !cnt_clear |=> match_interrupt && cnt_q == 18'h0_0000)
        else $error("match did not clear counter");
    a_wrap_sets_ovf: assert property (@(posedge core_clk) disable iff (reset)
        cnt_tick && !hit && cnt_q == WGCT_CNT_MAX |=> ovf_q)
        else $error("wrap did not set overflow");
    a_ovf_holds: assert property (@(posedge core_clk) disable iff (reset)
        ovf_q && !cnt_clear |=> ovf_q)
        else $error("overflow dropped without clear");
    a_event_counts: assert property (@(posedge core_clk) disable iff (reset)
        (running && ck_sel == WGCT_CK_EXT && !hit && !cnt_clear) and s_fall_seen
        |=> cnt_q == $past(cnt_q) + 18'h0_0001)
        else $error("falling edge not counted");
    a_event_idle: assert property (@(posedge core_clk) disable iff (reset)
        ck_sel == WGCT_CK_EXT && !ext_fall && !cnt_clear |=> cnt_q == $past(cnt_q))
        else $error("event count moved without edge");
    a_cr2_fixed: assert property (@(posedge core_clk) disable iff (reset)
        wr_cr2 |=> cr2_q[7] == 1'b0 && cr2_q[1:0] == 2'b10)
        else $error("control two fixed bits wrong");
    a_gate_fall_irq: assert property (@(posedge core_clk) disable iff (reset)
        running && gate_prev_q && !gate_now |=> gate_interrupt)
        else $error("falling gate edge missed");
    a_gate_rise_only: assert property (@(posedge core_clk) disable iff (reset)
        running && !edge_both && !gate_prev_q && gate_now |=> !gate_interrupt)
        else $error("rising edge raised irq in fall mode");
    a_stopped_still: assert property (@(posedge core_clk) disable iff (reset)
        !running && !cnt_clear |=> cnt_q == $past(cnt_q))
        else $error("stopped counter moved");
endmodule
`default_nettype wire

// *** dv/wgct_pulse_src.sv ***
// Partner model: external pulse source feeding the count input pin
`default_nettype none
module wgct_pulse_src
(
    input  wire logic core_clk,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Half period of 9 clocks (HALF plus the lead-in edge) keeps the pin at an eighteenth of the clock
    localparam int HALF = 8;
    initial pin = 1'b0;
    // Change just after an edge, then hold the level for HALF clocks
    task automatic level(input logic v);
        @(posedge core_clk);
        pin <= v;
        repeat (HALF) @(posedge core_clk);
    endtask
    // Whole pulses only, never a runt level
    task automatic pulses(input int n);
        repeat (n)
        begin
            level(1'b1);
            level(1'b0);
        end
    endtask
endmodule
`default_nettype wire

// *** dv/wgct_top_tb.sv ***
// Self-checking bench for the window gated counter timer
`default_nettype none
module wgct_top_tb
    import wgct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {string nm; logic [31:0] v;} wgct_exp_t;
    logic        core_clk, reset, hsel, hwrite, rd_dp, ext_pin;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, match_interrupt, gate_interrupt;
    int          n_mismatch, cmp_count, n_match, n_gate;
    longint      cyc, t_m[2], t_g[2];
    wgct_exp_t   exp_q[$], x;

    wgct_top i_wgct_top (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .external_count_input(ext_pin), .match_interrupt(match_interrupt),
        .gate_interrupt(gate_interrupt));
    wgct_pulse_src i_wgct_pulse_src (.core_clk(core_clk), .pin(ext_pin));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Stamps interrupt pulses; read data is taken at the edge closing its data phase
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (match_interrupt === 1'b1)
        begin
            n_match <= n_match + 1;
            t_m <= '{t_m[1], cyc};
        end
        if (gate_interrupt === 1'b1)
        begin
            n_gate <= n_gate + 1;
            t_g <= '{t_g[1], cyc};
        end
        if (rd_dp === 1'b1 && hreadyout === 1'b1)
        begin
            x = exp_q.pop_front();
            chk(x.nm, x.v, hrdata);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bounded wait for hready; a hung slave ends the run
    task automatic wait_rdy();
        int k;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    // Single word transfer: address phase, then data phase, each held until hready
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h00_0000, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_dp <= ~w;
        wait_rdy();
        rd_dp <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] e, input string nm);
        exp_q.push_back('{nm, e});
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // Interrupt counts may lag the edge by a few cycles, so waits are bounded loops
    task automatic wait_irq(input bit g, input int n);
        int k;
        for (k = 0; k < 20000 && (g ? n_gate : n_match) < n; k++)
            @(posedge core_clk);
        if (k == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int c, k, m0, g0;
        logic [7:0] v;
        {reset, hsel, hwrite, rd_dp, htrans, hsize} = {1'b1, 5'h00, 3'h2};
        {haddr, hwdata, cyc, n_match, n_gate, n_mismatch, cmp_count} = '0;
        void'($urandom(46));
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        // Reset values, read-only status and an unmapped hole
        rd(WGCT_ADDR_CTRL1, 32'h0000_0088, "ctrl1");
        rd(WGCT_ADDR_CTRL2, 32'h0000_0002, "ctrl2");
        bus(1'b1, WGCT_ADDR_STATUS, 32'h0000_00FF);
        rd(WGCT_ADDR_STATUS, 32'h0000_0000, "status");
        rd(WGCT_ADDR_GATEPER, 32'h0000_0000, "gate period");
        bus(1'b1, 10'h3F0, 32'hFFFF_FFFF);
        rd(10'h3F0, 32'h0000_0000, "unmapped");
        // Every gate source and gate clock code, random edge choice, while stopped
        for (k = 0; k < 16; k++)
        begin
            v = {1'b0, k[3:2], 1'($urandom), k[1:0], 2'b10};
            bus(1'b1, WGCT_ADDR_CTRL2, {24'h00_0000, v});
            rd(WGCT_ADDR_CTRL2, {24'h00_0000, v}, "ctrl2");
        end
        // Event counting with the pin as gate, falling-only then both edges
        for (int e = 0; e < 2; e++)
        begin
            c = 6 + $urandom % 5;
            k = 2 + $urandom % 3;
            bus(1'b1, WGCT_ADDR_CTRL1, 32'h0000_008E);
            bus(1'b1, WGCT_ADDR_CTRL1, 32'h0000_000E);
            bus(1'b1, WGCT_ADDR_CTRL2, {27'h000_0000, 1'(e), 4'b0010});
            bus(1'b1, WGCT_ADDR_COMPARE, c);
            bus(1'b1, WGCT_ADDR_CTRL1, 32'h0000_00AE);
            {m0, g0} = {n_match, n_gate};
            i_wgct_pulse_src.pulses(k);
            i_wgct_pulse_src.level(1'b1);
            rd(WGCT_ADDR_STATUS, 32'h0000_0080, "status high");
            i_wgct_pulse_src.level(1'b0);
            rd(WGCT_ADDR_COMPARE, k + 1, "count");
            chk("gate irqs", (k + 1) * (e + 1), n_gate - g0);
            // Fall c reaches the compare value; the match clears on the following fall
            i_wgct_pulse_src.pulses(c - k);
            chk("match irqs", 1, n_match - m0);
            rd(WGCT_ADDR_COMPARE, 32'h0000_0000, "count");
            bus(1'b1, WGCT_ADDR_CTRL1, 32'h0000_008E);
            rd(WGCT_ADDR_STATUS, 32'h0000_0000, "status off");
        end
        // Timer mode on fc: match clears, so pulses recur every compare plus one
        c = 4 + $urandom % 8;
        bus(1'b1, WGCT_ADDR_CTRL1, 32'h0000_0080);
        bus(1'b1, WGCT_ADDR_CTRL1, 32'h0000_0000);
        bus(1'b1, WGCT_ADDR_COMPARE, c);
        bus(1'b1, WGCT_ADDR_CTRL1, 32'h0000_00A0);
        wait_irq(1'b0, n_match + 3);
        chk("match period", c + 1, 32'(t_m[1] - t_m[0]));
        // Slow mode on fc: low compare bits are ignored, so any low value gives one period
        bus(1'b1, WGCT_ADDR_CTRL1, 32'h0000_0080);
        bus(1'b1, WGCT_ADDR_SYSMODE, 32'h0000_0002);
        bus(1'b1, WGCT_ADDR_COMPARE, 32'h0000_0800 + $urandom % 2048);
        bus(1'b1, WGCT_ADDR_CTRL1, 32'h0000_0000);
        bus(1'b1, WGCT_ADDR_CTRL1, 32'h0000_00A0);
        wait_irq(1'b0, n_match + 3);
        chk("slow match period", 32'h0000_0801, 32'(t_m[1] - t_m[0]));
        bus(1'b1, WGCT_ADDR_CTRL1, 32'h0000_0080);
        bus(1'b1, WGCT_ADDR_SYSMODE, 32'h0000_0000);
        // Internal gate, one tick each phase, both edges: 4096 clocks apart
        bus(1'b1, WGCT_ADDR_CTRL1, 32'h0000_0080);
        bus(1'b1, WGCT_ADDR_GATEPER, 32'h0000_00FF);
        bus(1'b1, WGCT_ADDR_CTRL2, 32'h0000_0032);
        bus(1'b1, WGCT_ADDR_COMPARE, 32'h0003_FFFF);
        bus(1'b1, WGCT_ADDR_CTRL1, 32'h0000_00A0);
        wait_irq(1'b1, n_gate + 3);
        chk("gate period", 32'h0000_1000, 32'(t_g[1] - t_g[0]));
        report_and_stop();
    end
endmodule
`default_nettype wire
